// file: adcso_chk_sva.sv
`timescale 1ns/1ns
module adcso_chk
   import adcso_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic format_continuous,
   input wire logic clock_internal,
   input wire logic serial_clk,
   input wire logic serial_data_out,
   input wire logic serial_word_strobe_n,
   input wire logic busy_n,
   input wire logic [RESULT_BITS-1:0] parallel_result_bits
);
   int cnt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Busy low length
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
      end else begin
         cnt <= busy_n ? 0 : cnt + 1;
      end
   end
   idle_gated_a: assert property (busy_n && !format_continuous && !$past(format_continuous, 8) |-> !serial_clk)
      else $error("clock runs idle");
   bit_hold_a: assert property ($fell(serial_clk) |-> $stable(serial_data_out))
      else $error("data moved at fall");
   shift_now_a: assert property ($fell(busy_n) |-> ##[1:40] $rose(serial_clk))
      else $error("no shift in conversion");
   free_clk_a: assert property (format_continuous && $past(format_continuous, 8) |-> ##[1:40] $changed(serial_clk))
      else $error("clock stopped");
   strobe_a: assert property (format_continuous && $fell(busy_n) |-> ##[1:120] !serial_word_strobe_n)
      else $error("no strobe");
   busy_hold_a: assert property ($fell(busy_n) |-> !busy_n [*8])
      else $error("busy released early");
   conv_len_a: assert property ($rose(busy_n) |->
      (clock_internal ? (cnt >= 305 && cnt <= 335) : (cnt >= 118 && cnt <= 140)))
      else $error("bad conversion length");
   result_a: assert property ($rose(busy_n) |-> $stable(parallel_result_bits))
      else $error("result moved at busy rise");
endmodule
bind adcso_top adcso_chk chk (.*);

// file: adcso_pkg.sv
package adcso_pkg;
   localparam int SYS_CLK_PERIOD_NS = 20;
   localparam int INT_CONV_HALF_NS = 200;
   localparam int INT_HALF_CYCLES_I = (INT_CONV_HALF_NS / SYS_CLK_PERIOD_NS < 1) ? 1 :
      INT_CONV_HALF_NS / SYS_CLK_PERIOD_NS;
   localparam logic [7:0] INT_HALF_CYCLES = INT_HALF_CYCLES_I[7:0];
   localparam int RESULT_BITS = 12;
   localparam int WORD_BITS = 16;
   localparam logic [5:0] CONV_HALF_TICKS = 6'h20;
   localparam logic [11:0] RESULT_RESET = 12'h000;

   typedef enum logic [2:0] {
      ADCSO_IDLE = 3'b001,
      ADCSO_CONV = 3'b010,
      ADCSO_DONE = 3'b100
   } adcso_state_t;

   typedef struct packed {
      logic clk;
      logic data;
      logic strobe_n;
   } adcso_serial_t;
endpackage

// file: adcso_rx.sv
`timescale 1ns/1ns
module adcso_rx
   import adcso_pkg::*;
(
   input wire logic serial_clk,
   input wire logic serial_data_out,
   input wire logic serial_word_strobe_n,
   input wire logic format_continuous,
   input wire logic busy_n,
   input wire logic [RESULT_BITS-1:0] parallel_result_bits,
   output logic [WORD_BITS-1:0] word,
   output int bits,
   output logic [RESULT_BITS-1:0] latched
);
   wire logic sclk_inv = ~serial_clk;
   initial bits = 0;
   always @(posedge sclk_inv) begin
      if (!format_continuous || !serial_word_strobe_n) begin
         word <= {word[WORD_BITS-2:0], serial_data_out};
         bits <= bits + 1;
      end
   end
   always @(posedge busy_n) latched <= parallel_result_bits;
endmodule

// file: adcso_sync.sv
`timescale 1ns/1ns
module adcso_sync (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic next_level;

   always_comb begin
      next_stage = {stage[1:0], async_in};
      next_level = (stage[2] == stage[1]) ? stage[1] : level;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage <= 3'h0;
         level <= 1'b0;
      end else begin
         stage <= next_stage;
         level <= next_level;
      end
   end

   assign rise = next_level & ~level;
   assign fall = ~next_level & level;
endmodule

// file: adcso_top.sv
`timescale 1ns/1ns
module adcso_top
   import adcso_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic format_continuous,
   input wire logic clock_internal,
   input wire logic ext_conv_clk,
   input wire logic standalone_mode,
   input wire logic conv_start_n,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic [RESULT_BITS-1:0] sample_in,
   output logic serial_clk,
   output logic serial_data_out,
   output logic serial_word_strobe_n,
   output logic busy_n,
   output logic [RESULT_BITS-1:0] parallel_result_bits,
   output logic parallel_oe
);
   logic rst_meta_n;
   logic rst_sync_n;
   logic ext_clk_level;
   logic ext_clk_rise;
   logic ext_clk_fall;
   logic start_level;
   logic start_fall;
   logic cs_level;
   logic cs_fall;
   logic rd_level;
   logic fmt_level;
   logic int_level;
   logic sa_level;
   logic [7:0] div_cnt;
   logic [7:0] next_div_cnt;
   logic half_tick;
   logic phase_high;
   logic next_phase_high;
   adcso_state_t state;
   adcso_state_t next_state;
   logic [5:0] tick_cnt;
   logic [5:0] next_tick_cnt;
   logic [WORD_BITS-1:0] shift;
   logic [WORD_BITS-1:0] next_shift;
   logic [RESULT_BITS-1:0] held;
   logic [RESULT_BITS-1:0] next_held;
   logic [RESULT_BITS-1:0] next_result;
   adcso_serial_t ser;
   adcso_serial_t next_ser;
   logic next_busy_n;
   logic next_oe;
   logic start_req;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   adcso_sync u_ext_clk (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .async_in(ext_conv_clk),
      .level(ext_clk_level),
      .rise(ext_clk_rise),
      .fall(ext_clk_fall)
   );

   adcso_sync u_start (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .async_in(~conv_start_n),
      .level(start_level),
      .rise(start_fall),
      .fall()
   );

   adcso_sync u_cs (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .async_in(~cs_n),
      .level(cs_level),
      .rise(cs_fall),
      .fall()
   );

   adcso_sync u_rd (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .async_in(~rd_n),
      .level(rd_level),
      .rise(),
      .fall()
   );

   adcso_sync u_fmt (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .async_in(format_continuous),
      .level(fmt_level),
      .rise(),
      .fall()
   );

   adcso_sync u_int (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .async_in(clock_internal),
      .level(int_level),
      .rise(),
      .fall()
   );

   adcso_sync u_sa (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .async_in(standalone_mode),
      .level(sa_level),
      .rise(),
      .fall()
   );

   // Conversion clock half periods
   always_comb begin
      next_div_cnt = 8'h00;
      half_tick = 1'b0;
      if (int_level) begin
         if (div_cnt >= INT_HALF_CYCLES - 8'h01) begin
            half_tick = 1'b1;
         end else begin
            next_div_cnt = div_cnt + 8'h01;
         end
      end else begin
         half_tick = ext_clk_rise | ext_clk_fall;
      end
      next_phase_high = half_tick ? ~phase_high : phase_high;
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         div_cnt <= 8'h00;
         phase_high <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         phase_high <= next_phase_high;
      end
   end

   assign start_req = sa_level ? cs_fall : start_fall;

   // Conversion sequence
   always_comb begin
      next_state = state;
      next_tick_cnt = tick_cnt;
      next_shift = shift;
      next_held = held;
      next_result = parallel_result_bits;
      next_busy_n = busy_n;
      next_ser = ser;
      case (state)
         ADCSO_IDLE: begin
            next_ser.data = 1'b0;
            next_ser.strobe_n = 1'b1;
            next_ser.clk = fmt_level ? phase_high : 1'b0;
            if (start_req) begin
               next_held = sample_in;
               next_shift = {{(WORD_BITS-RESULT_BITS){1'b0}}, sample_in};
               next_tick_cnt = 6'h00;
               next_busy_n = 1'b0;
               next_state = ADCSO_CONV;
            end
         end
         ADCSO_CONV: begin
            if (half_tick) begin
               next_tick_cnt = tick_cnt + 6'h01;
               if (!tick_cnt[0]) begin
                  next_ser.clk = 1'b1;
                  next_ser.data = shift[WORD_BITS-1];
                  next_ser.strobe_n = ~fmt_level;
                  next_shift = {shift[WORD_BITS-2:0], 1'b0};
               end else begin
                  next_ser.clk = 1'b0;
               end
               if (tick_cnt == CONV_HALF_TICKS - 6'h01) begin
                  next_result = held;
                  next_state = ADCSO_DONE;
               end
            end
         end
         ADCSO_DONE: begin
            next_busy_n = 1'b1;
            next_ser.strobe_n = 1'b1;
            next_ser.data = 1'b0;
            next_state = ADCSO_IDLE;
         end
         default: begin
            next_state = ADCSO_IDLE;
            next_busy_n = 1'b1;
         end
      endcase
      next_oe = rd_level & (sa_level | cs_level);
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= ADCSO_IDLE;
         tick_cnt <= 6'h00;
         shift <= 16'h0000;
         held <= RESULT_RESET;
         parallel_result_bits <= RESULT_RESET;
         busy_n <= 1'b1;
         ser <= '{clk: 1'b0, data: 1'b0, strobe_n: 1'b1};
         parallel_oe <= 1'b0;
      end else begin
         state <= next_state;
         tick_cnt <= next_tick_cnt;
         shift <= next_shift;
         held <= next_held;
         parallel_result_bits <= next_result;
         busy_n <= next_busy_n;
         ser <= next_ser;
         parallel_oe <= next_oe;
      end
   end

   assign serial_clk = ser.clk;
   assign serial_data_out = ser.data;
   assign serial_word_strobe_n = ser.strobe_n;
endmodule

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
   import adcso_pkg::*;
   logic sys_clk, rst_n, format_continuous, clock_internal, ext_conv_clk, standalone_mode, conv_start_n, cs_n;
   logic rd_sel_n, serial_clk, serial_data_out, serial_word_strobe_n, busy_n, parallel_oe;
   logic [RESULT_BITS-1:0] sample_in, parallel_result_bits, latched;
   logic [WORD_BITS-1:0] word;
   int bits, n_fail, comparisons, cyc, b0;
   wire logic rd_n = standalone_mode ? busy_n : rd_sel_n;
`define CHK(a, b) begin comparisons++; \
   if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t got %h", $time, a); end end
   adcso_top dut (.*);
   adcso_rx rx (.*);
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      ext_conv_clk = 1'b0;
      #3;
      forever #80 ext_conv_clk = ~ext_conv_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wait_busy(input logic lvl);
      for (int i = 0; i < 400 && busy_n !== lvl; i++) begin
         @(posedge sys_clk);
      end
      `CHK(busy_n, lvl)
   endtask
   task automatic convert(input logic fmt, ci, sa, input logic [11:0] s);
      format_continuous <= fmt;
      clock_internal <= ci;
      standalone_mode <= sa;
      sample_in <= s;
      repeat (10) @(posedge sys_clk);
      b0 = bits;
      cs_n <= !sa;
      conv_start_n <= sa;
      wait_busy(1'b0);
      sample_in <= ~s;
      conv_start_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      conv_start_n <= 1'b0;
      wait_busy(1'b1);
      `CHK(latched, s)
      `CHK(word[11:0], s)
      if (!fmt) `CHK({bits - b0, word[15:12]}, {32'h10, 4'h0})
      repeat (30) @(posedge sys_clk);
      `CHK({busy_n, serial_clk & ~fmt}, 2'b10)
      conv_start_n <= 1'b1;
      cs_n <= 1'b1;
   endtask
   initial begin
      rst_n = 1'b0;
      format_continuous = 1'b0;
      clock_internal = 1'b1;
      standalone_mode = 1'b0;
      conv_start_n = 1'b1;
      cs_n = 1'b1;
      rd_sel_n = 1'b1;
      sample_in = '0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge sys_clk);
      convert(1'b0, 1'b0, 1'b1, 12'hfff);
      convert(1'b1, 1'b1, 1'b1, 12'h801);
      convert(1'b0, 1'b1, 1'b0, 12'ha5c);
      convert(1'b1, 1'b0, 1'b0, 12'h3c9);
      cs_n <= 1'b0;
      rd_sel_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      `CHK({parallel_oe, parallel_result_bits}, {1'b1, 12'h3c9})
      end_sim();
   end
endmodule
